/* bench/tb_prescaled_interval_timer.sv */
`timescale 1ns/10ps
`default_nettype none
`include "interval_timer_defs.svh"

module tb_prescaled_interval_timer
    import interval_timer_pkg::*;
;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    int failures = 0;
    int checks = 0;
    int cyc = 0;
    logic [33:0] expq[$];
    logic [33:0] mon_e;

    prescaled_interval_timer uut (.mclk(mclk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

    // Free running clock, 5 ns period
    always #2.5 mclk = ~mclk;

    task automatic check_val(input string name, input logic [32:0] seen, input logic [32:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Cycle count and hang guard; the whole run needs a few hundred cycles
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            failures++;
            summarize();
        end
    end

    // Monitor: each answered transfer takes the oldest note; writes only check the error flag
    always @(posedge mclk)
        if (pready === 1'b1)
        begin
            mon_e = expq.pop_front();
            if (mon_e[33])
                check_val("read", {pslverr, prdata}, mon_e[32:0]);
            else
                check_val("write_err", {pslverr, 32'h0}, {mon_e[32], 32'h0});
        end

    // One APB transfer; request held until pready is sampled high
    task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d,
        input logic [32:0] e);
        expq.push_back({~w, e});
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Let a registered irq drop settle first, then wait for it with a bound
    task automatic wait_irq(output int t);
        int n;
        n = 0;
        repeat (2) @(posedge mclk);
        while (irq !== 1'b1 && n < 3000)
        begin
            @(posedge mclk);
            n++;
        end
        t = cyc;
    endtask

    initial
    begin
        int s;
        int p;
        int t1;
        int t2;
        s = $urandom(32'haf50);
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        // Every mapped word reads zero after reset, an unmapped one is refused
        for (int i = 0; i < 6; i++)
            bus(12'(i * 4), 1'b0, 32'h0, 33'h0);
        bus(12'h018, 1'b0, 32'h0, {1'b1, 32'h0});
        // Program while disabled: nothing may move
        s = $urandom % 4;
        p = 10 + $urandom % 8;
        bus(`OFS_PRESCALE, 1'b1, 32'(s), 33'h0);
        bus(`OFS_PERIOD, 1'b1, 32'(p), 33'h0);
        bus(`OFS_COUNT, 1'b1, 32'(p), 33'h0);
        repeat (20) @(posedge mclk);
        bus(`OFS_COUNT, 1'b0, 32'h0, {1'b0, 32'(p)});
        bus(`OFS_PRESCALE, 1'b0, 32'h0, {1'b0, 32'(s)});
        bus(`OFS_PERIOD, 1'b0, 32'h0, {1'b0, 32'(p)});
        bus(`OFS_STATUS, 1'b0, 32'h0, 33'h0);
        // Run unmasked: spacing of zero events is period times divisor
        bus(`OFS_MASK, 1'b1, 32'h1, 33'h0);
        bus(`OFS_CONTROL, 1'b1, 32'h1, 33'h0);
        wait_irq(t1);
        bus(`OFS_STATUS, 1'b0, 32'h0, 33'h1);
        wait_irq(t2);
        check_val("interval", 33'(t2 - t1), 33'(p * (s + 1)));
        // Masked: the event is still recorded but irq stays low
        bus(`OFS_MASK, 1'b1, 32'h0, 33'h0);
        bus(`OFS_STATUS, 1'b0, 32'h0, 33'h1);
        repeat (p * (s + 1) + 4) @(posedge mclk);
        check_val("irq_masked", {32'h0, irq}, 33'h0);
        bus(`OFS_STATUS, 1'b0, 32'h0, 33'h1);
        // Reset in mid-run, then a divisor of two from a freshly loaded divider
        reset_n <= 1'b0;
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        check_val("irq_reset", {32'h0, irq}, 33'h0);
        bus(`OFS_STATUS, 1'b0, 32'h0, 33'h0);
        bus(`OFS_PRESCALE, 1'b1, 32'h1, 33'h0);
        bus(`OFS_COUNT, 1'b1, 32'(p), 33'h0);
        bus(`OFS_MASK, 1'b1, 32'h1, 33'h0);
        bus(`OFS_CONTROL, 1'b1, 32'h1, 33'h0);
        t1 = cyc;
        wait_irq(t2);
        // Enable lands one edge before the write completes: first event 2p edges later
        check_val("first_interval", 33'(t2 - t1), 33'(p * 2));
        repeat (4) @(posedge mclk);
        summarize();
    end
endmodule

`default_nettype wire

/* logic/interval_timer_defs.svh */
`ifndef INTERVAL_TIMER_DEFS_SVH
`define INTERVAL_TIMER_DEFS_SVH

// Register byte offsets on the APB word map
`define OFS_CONTROL 12'h000
`define OFS_COUNT 12'h004
`define OFS_PRESCALE 12'h008
`define OFS_PERIOD 12'h00C
`define OFS_STATUS 12'h010
`define OFS_MASK 12'h014

// Field positions
`define CTRL_ENABLE_BIT 0
`define STAT_ZERO_BIT 0

// Reset values
`define RST_COUNT 16'h0000
`define RST_PRESCALE 8'h00
`define RST_PERIOD 16'h0000

`endif

/* logic/interval_timer_pkg.sv */
package interval_timer_pkg;

    // APB request as seen by the slave
    typedef struct packed {
        logic [11:0] addr;
        logic write;
        logic [31:0] wdata;
    } apb_req_s;

endpackage

/* logic/prescaled_interval_timer.sv */
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "interval_timer_defs.svh"

module prescaled_interval_timer
    import interval_timer_pkg::*;
#(
    parameter int COUNT_W = 16,
    parameter int SCALE_W = 8
)
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);

    // The register map fixes both widths; other values are refused at elaboration
    if (COUNT_W != 16 || SCALE_W != 8)
    begin : g_width_check
        $error("Widths are fixed by the register map");
    end

    apb_req_s req;
    logic [15:0] count_value;
    logic [7:0] prescale_value;
    logic [15:0] reload_period;
    logic [7:0] scale_ctr;
    logic enable;
    logic zero_status;
    logic zero_mask;
    logic tick;
    logic zero_hit;
    logic wr_en;
    logic rd_en;
    logic next_zero_status;
    logic next_zero_mask;

    // Bus request bundled for decode
    assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
    // Access phase of a transfer; the slave answers after one wait state
    assign wr_en = psel && penable && req.write && !pready;
    assign rd_en = psel && penable && !req.write && !pready;

    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a == `OFS_CONTROL) || (a == `OFS_COUNT) || (a == `OFS_PRESCALE)
            || (a == `OFS_PERIOD) || (a == `OFS_STATUS) || (a == `OFS_MASK);
    endfunction

    // Prescale tick when the divider has run out
    assign tick = enable && (scale_ctr == 8'h00);
    assign zero_hit = tick && (count_value == 16'h0001);

    // Control and mask registers
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            enable <= 1'b0;
            zero_mask <= 1'b0;
        end
        else if (wr_en && req.addr == `OFS_CONTROL)
            enable <= req.wdata[`CTRL_ENABLE_BIT];
        else if (wr_en && req.addr == `OFS_MASK)
            zero_mask <= req.wdata[`STAT_ZERO_BIT];
    end

    // Prescale and period hold unless software writes them
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            prescale_value <= `RST_PRESCALE;
            reload_period <= `RST_PERIOD;
        end
        else if (wr_en && req.addr == `OFS_PRESCALE)
            prescale_value <= req.wdata[7:0];
        else if (wr_en && req.addr == `OFS_PERIOD)
            reload_period <= req.wdata[15:0];
    end

    // Divider counts s down to zero, giving s+1 cycles per tick
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
            scale_ctr <= 8'h00;
        else if (wr_en && req.addr == `OFS_PRESCALE)
            scale_ctr <= req.wdata[7:0];
        else if (enable)
        begin
            if (scale_ctr == 8'h00)
                scale_ctr <= prescale_value;
            else
                scale_ctr <= scale_ctr - 8'h01;
        end
    end

    // Down-counter; a software write wins over a tick in the same cycle
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
            count_value <= `RST_COUNT;
        else if (wr_en && req.addr == `OFS_COUNT)
            count_value <= req.wdata[15:0];
        else if (tick)
        begin
            if (zero_hit || count_value == 16'h0000)
                count_value <= reload_period;
            else
                count_value <= count_value - 16'h0001;
        end
    end

    // Sticky zero flag: an event in the read cycle wins over the clear
    always_comb
    begin
        next_zero_status = zero_status;
        if (rd_en && req.addr == `OFS_STATUS)
            next_zero_status = 1'b0;
        if (zero_hit)
            next_zero_status = 1'b1;
    end

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
            zero_status <= 1'b0;
        else
            zero_status <= next_zero_status;
    end

    // Mask as it stands after this edge, so irq never lags a mask write
    assign next_zero_mask = (wr_en && req.addr == `OFS_MASK) ? req.wdata[`STAT_ZERO_BIT]
        : zero_mask;

    // Level interrupt from a flop, in step with the flag and the mask
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
            irq <= 1'b0;
        else
            irq <= next_zero_status && next_zero_mask;
    end

    // APB answer: pready in the second access cycle, error on unmapped offsets
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !is_mapped(req.addr);
            prdata <= 32'h0000_0000;
            if (rd_en)
            begin
                unique case (req.addr)
                    `OFS_CONTROL: prdata <= {31'h0, enable};
                    `OFS_COUNT: prdata <= {16'h0000, count_value};
                    `OFS_PRESCALE: prdata <= {24'h00_0000, prescale_value};
                    `OFS_PERIOD: prdata <= {16'h0000, reload_period};
                    `OFS_STATUS: prdata <= {31'h0, zero_status};
                    `OFS_MASK: prdata <= {31'h0, zero_mask};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Checks
    property p_hold_disabled;
        @(posedge mclk) disable iff (!reset_n)
        (!enable && !wr_en) |=> $stable(count_value) && $stable(scale_ctr);
    endproperty
    a_hold_disabled: assert property (p_hold_disabled) else $error("Count moved while disabled");

    property p_decrement;
        @(posedge mclk) disable iff (!reset_n)
        (tick && !wr_en && count_value > 16'h0001) |=> count_value == $past(count_value) - 16'h0001;
    endproperty
    a_decrement: assert property (p_decrement) else $error("Count did not decrement");

    property p_reload;
        @(posedge mclk) disable iff (!reset_n)
        (zero_hit && !wr_en) |=> count_value == $past(reload_period);
    endproperty
    a_reload: assert property (p_reload) else $error("Count did not reload");

    property p_flag_set;
        @(posedge mclk) disable iff (!reset_n)
        zero_hit |=> zero_status;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("Zero flag not set");

    sequence s_scale_zero;
        enable && !wr_en && scale_ctr == 8'h00 && prescale_value == 8'h01;
    endsequence
    sequence s_two_cycles;
        enable && !wr_en ##1 enable && !wr_en;
    endsequence
    property p_period;
        @(posedge mclk) disable iff (!reset_n)
        (s_scale_zero ##0 s_two_cycles) |=> scale_ctr == 8'h00;
    endproperty
    a_period: assert property (p_period) else $error("Prescale period wrong");

    property p_irq;
        @(posedge mclk) disable iff (!reset_n)
        irq == (zero_status && zero_mask);
    endproperty
    a_irq: assert property (p_irq) else $error("Interrupt not raised");

endmodule
`default_nettype wire
